// ==== logic/irq_seq_pkg.sv ====
package irq_seq_pkg;

  // Cycle budgets of the sequencer, in core_clk cycles.
  localparam int unsigned DISPATCH_CYCLES    = 13;
  localparam int unsigned LONG_JUMP_CYCLES   = 7;
  localparam int unsigned SHORT_JUMP_CYCLES  = 5;
  localparam int unsigned CNT_W              = 4;

  localparam logic [3:0] DISPATCH_LAST    = 4'(DISPATCH_CYCLES - 1);
  localparam logic [3:0] LONG_JUMP_LAST   = 4'(LONG_JUMP_CYCLES - 1);
  localparam logic [3:0] SHORT_JUMP_LAST  = 4'(SHORT_JUMP_CYCLES - 1);

  // Dispatch steps, counted from the first dispatch cycle.
  localparam logic [3:0] STEP_PUSH_HIGH   = 4'h0;
  localparam logic [3:0] STEP_PUSH_LOW    = 4'h1;
  localparam logic [3:0] STEP_PUSH_FLAGS  = 4'h2;
  localparam logic [3:0] STEP_VECTOR      = 4'h3;

  // Flags word layout and reset values.
  localparam int unsigned INT_EN_BIT      = 0;
  localparam logic [7:0]  FLAGS_RESET     = 8'h00;
  localparam logic [15:0] PC_RESET        = 16'h0000;

  // Vector table: first entry and spacing between entries.
  localparam logic [7:0]  VEC_BASE        = 8'h04;
  localparam logic [7:0]  VEC_STEP        = 8'h04;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_DISPATCH,
    ST_VJUMP
  } seq_state_t;

endpackage

// ==== logic/irq_posting.sv ====
module irq_posting #(
  parameter int unsigned N_IRQ = 8
) (
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic [N_IRQ-1:0] int_cond,
  input  wire logic [N_IRQ-1:0] int_clr,
  input  wire logic [N_IRQ-1:0] int_mask_regs,
  input  wire logic             ack,
  output logic                  any_pending,
  output logic [7:0]            vector
);

  typedef struct packed {
    logic [N_IRQ-1:0] posted;
  } post_state_t;

  post_state_t s_q;
  post_state_t s_d;
  logic [N_IRQ-1:0] pending;
  logic [N_IRQ-1:0] win;

  // Mask only gates pending; posting and posted bits ignore it.
  assign pending     = s_q.posted & int_mask_regs;
  assign any_pending = |pending;

  // Lowest index has the highest priority.
  always_comb
  begin
    win    = '0;
    vector = irq_seq_pkg::VEC_BASE;
    for (int i = N_IRQ - 1; i >= 0; i--)
    begin
      if (pending[i])
      begin
        win    = '0;
        win[i] = 1'b1;
        vector = 8'(irq_seq_pkg::VEC_BASE + 8'(i) * irq_seq_pkg::VEC_STEP);
      end
    end
  end

  always_comb
  begin
    s_d = s_q;
    // A new condition wins over a clear or an acknowledge in the same cycle.
    s_d.posted = int_cond | (s_q.posted & ~int_clr & ~(ack ? win : '0));
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

endmodule

// ==== logic/irq_sequencer.sv ====
// Behaviour
// - Service routine runs with global enable cleared; software may set it for nesting.
// - Return reloads program counter and flags, so the enable comes back.
// - After return, pending interrupts dispatch before the next normal instruction.
// - Latency is remaining instruction cycles plus dispatch plus vector long jump.
// - Dispatch takes exactly 13 cycles; vector long jump takes 7 cycles.
// - Short jump takes 5 cycles, so 1 to 5 cycles precede dispatch.
// - Dispatch pushes high byte, low byte, flags; clears flags; loads vector.
// - Activation by condition, by unmasking posted request, or by enable rising.
// - Clearing a mask bit keeps posted requests and still lets new ones post.
module irq_sequencer #(
  parameter int unsigned N_IRQ = 8
) (
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic [N_IRQ-1:0] int_cond,
  input  wire logic [N_IRQ-1:0] int_clr,
  input  wire logic [N_IRQ-1:0] int_mask_regs,
  input  wire logic             instr_start,
  input  wire logic             instr_is_short_jump,
  input  wire logic [3:0]       instr_cycles,
  input  wire logic [15:0]      next_pc,
  input  wire logic             flags_wr,
  input  wire logic [7:0]       flags_wdata,
  input  wire logic             ret_valid,
  input  wire logic [15:0]      ret_pc,
  input  wire logic [7:0]       ret_flags,
  input  wire logic [15:0]      vec_target,
  output logic                  instr_ready,
  output logic [15:0]           program_counter,
  output logic [7:0]            flags,
  output logic                  global_int_enable,
  output logic                  stack_wr,
  output logic [7:0]            stack_wdata,
  output logic                  instr_finish,
  output logic                  isr_start,
  output logic                  in_dispatch
);

  typedef struct packed {
    irq_seq_pkg::seq_state_t state;
    logic [3:0]              cnt;
    logic [15:0]             pc;
    logic [15:0]             pc_after;
    logic [7:0]              flags;
    logic                    stack_wr;
    logic [7:0]              stack_wdata;
    logic                    finish;
    logic                    isr_start;
  } seq_reg_t;

  seq_reg_t r_q;
  seq_reg_t r_d;

  logic       any_pending;
  logic [7:0] vector;
  logic       take_irq;
  logic       ack;
  logic [3:0] step;

  // Length of an instruction as a last-cycle index; zero length counts as one cycle.
  function automatic logic [3:0] exec_last(input logic       is_short,
                                           input logic [3:0] cycles);
    logic [3:0] res;
    res = 4'h0;
    if (is_short)
      res = irq_seq_pkg::SHORT_JUMP_LAST;
    else if (cycles != 4'h0)
      res = cycles - 4'h1;
    return res;
  endfunction

  irq_posting #(
    .N_IRQ (N_IRQ)
  ) u_posting (
    .core_clk      (core_clk),
    .resetn        (resetn),
    .int_cond      (int_cond),
    .int_clr       (int_clr),
    .int_mask_regs (int_mask_regs),
    .ack           (ack),
    .any_pending   (any_pending),
    .vector        (vector)
  );

  // Enable and pending are looked at each boundary, so a rising enable with a
  // request already pending is taken at the next boundary as well.
  assign take_irq = any_pending && r_q.flags[irq_seq_pkg::INT_EN_BIT];

  assign step = irq_seq_pkg::DISPATCH_LAST - r_q.cnt;
  assign ack  = (r_q.state == irq_seq_pkg::ST_DISPATCH) &&
                (step == irq_seq_pkg::STEP_VECTOR);

  // A new instruction is only accepted at a boundary with nothing to dispatch.
  assign instr_ready = (r_q.state == irq_seq_pkg::ST_IDLE) && !take_irq;

  assign program_counter   = r_q.pc;
  assign flags             = r_q.flags;
  assign global_int_enable = r_q.flags[irq_seq_pkg::INT_EN_BIT];
  assign stack_wr          = r_q.stack_wr;
  assign stack_wdata       = r_q.stack_wdata;
  assign instr_finish      = r_q.finish;
  assign isr_start         = r_q.isr_start;
  assign in_dispatch       = (r_q.state == irq_seq_pkg::ST_DISPATCH) ||
                             (r_q.state == irq_seq_pkg::ST_VJUMP);

  always_comb
  begin
    r_d           = r_q;
    r_d.stack_wr  = 1'b0;
    r_d.finish    = 1'b0;
    r_d.isr_start = 1'b0;

    // Software writes to the flags, including setting the enable inside a
    // service routine to allow nesting. Dispatch owns the flags meanwhile.
    if (flags_wr && !in_dispatch)
      r_d.flags = flags_wdata;

    case (r_q.state)
      irq_seq_pkg::ST_IDLE:
      begin
        if (take_irq)
        begin
          r_d.state = irq_seq_pkg::ST_DISPATCH;
          r_d.cnt   = irq_seq_pkg::DISPATCH_LAST;
        end
        else if (ret_valid)
        begin
          // The restored flags carry the enable that was set when the
          // routine was entered, so interrupts come back on here.
          r_d.pc    = ret_pc;
          r_d.flags = ret_flags;
        end
        else if (instr_start)
        begin
          r_d.state    = irq_seq_pkg::ST_EXEC;
          r_d.cnt      = exec_last(instr_is_short_jump, instr_cycles);
          r_d.pc_after = next_pc;
        end
      end

      irq_seq_pkg::ST_EXEC:
      begin
        if (r_q.cnt != 4'h0)
          r_d.cnt = r_q.cnt - 4'h1;
        else
        begin
          // The current instruction always runs to its end before dispatch.
          r_d.pc = r_q.pc_after;
          if (take_irq)
          begin
            r_d.state = irq_seq_pkg::ST_DISPATCH;
            r_d.cnt   = irq_seq_pkg::DISPATCH_LAST;
          end
          else
          begin
            r_d.state  = irq_seq_pkg::ST_IDLE;
            r_d.finish = 1'b1;
          end
        end
      end

      irq_seq_pkg::ST_DISPATCH:
      begin
        case (step)
          irq_seq_pkg::STEP_PUSH_HIGH:
          begin
            r_d.stack_wr    = 1'b1;
            r_d.stack_wdata = r_q.pc[15:8];
          end
          irq_seq_pkg::STEP_PUSH_LOW:
          begin
            r_d.stack_wr    = 1'b1;
            r_d.stack_wdata = r_q.pc[7:0];
          end
          irq_seq_pkg::STEP_PUSH_FLAGS:
          begin
            r_d.stack_wr    = 1'b1;
            r_d.stack_wdata = r_q.flags;
          end
          irq_seq_pkg::STEP_VECTOR:
          begin
            // Clearing the flags drops the enable, masking further interrupts.
            r_d.flags = irq_seq_pkg::FLAGS_RESET;
            r_d.pc    = {8'h00, vector};
          end
          default:
          begin
            r_d.stack_wr = 1'b0;
          end
        endcase
        if (r_q.cnt != 4'h0)
          r_d.cnt = r_q.cnt - 4'h1;
        else
        begin
          r_d.state = irq_seq_pkg::ST_VJUMP;
          r_d.cnt   = irq_seq_pkg::LONG_JUMP_LAST;
        end
      end

      irq_seq_pkg::ST_VJUMP:
      begin
        if (r_q.cnt != 4'h0)
          r_d.cnt = r_q.cnt - 4'h1;
        else
        begin
          r_d.pc        = vec_target;
          r_d.state     = irq_seq_pkg::ST_IDLE;
          r_d.isr_start = 1'b1;
        end
      end

      default:
      begin
        r_d.state = irq_seq_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      r_q.state       <= irq_seq_pkg::ST_IDLE;
      r_q.cnt         <= 4'h0;
      r_q.pc          <= irq_seq_pkg::PC_RESET;
      r_q.pc_after    <= irq_seq_pkg::PC_RESET;
      r_q.flags       <= irq_seq_pkg::FLAGS_RESET;
      r_q.stack_wr    <= 1'b0;
      r_q.stack_wdata <= 8'h00;
      r_q.finish      <= 1'b0;
      r_q.isr_start   <= 1'b0;
    end
    else
      r_q <= r_d;
  end

endmodule

// ==== sim/irq_checker.sv ====
module irq_checker (
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        flags_wr,
  input wire logic [7:0]  flags_wdata,
  input wire logic        ret_valid,
  input wire logic [15:0] ret_pc,
  input wire logic [7:0]  ret_flags,
  input wire logic        instr_start,
  input wire logic        instr_is_short_jump,
  input wire logic        instr_ready,
  input wire logic [15:0] program_counter,
  input wire logic [7:0]  flags,
  input wire logic        global_int_enable,
  input wire logic        stack_wr,
  input wire logic [7:0]  stack_wdata,
  input wire logic        instr_finish,
  input wire logic        isr_start,
  input wire logic        in_dispatch
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_isr_masked;
    isr_start |-> !global_int_enable;
  endproperty
  a_isr_masked: assert property (p_isr_masked)
    else $error("service routine entered with enable set");
  property p_take;
    $rose(in_dispatch) |-> $past(global_int_enable);
  endproperty
  a_take: assert property (p_take)
    else $error("dispatch taken while disabled");
  property p_ret;
    ret_valid && instr_ready |=> program_counter == $past(ret_pc) && flags == $past(ret_flags);
  endproperty
  a_ret: assert property (p_ret)
    else $error("return did not restore counter and flags");
  property p_len;
    $rose(in_dispatch) |-> ##20 isr_start;
  endproperty
  a_len: assert property (p_len)
    else $error("dispatch plus long jump length wrong");
  property p_short;
    instr_start && instr_ready && instr_is_short_jump |-> ##6 (instr_finish || in_dispatch);
  endproperty
  a_short: assert property (p_short)
    else $error("short jump length wrong");
  property p_push;
    $rose(in_dispatch) |=> stack_wr && stack_wdata == program_counter[15:8]
      ##1 stack_wr && stack_wdata == program_counter[7:0]
      ##1 stack_wr && stack_wdata == flags ##1 !stack_wr;
  endproperty
  a_push: assert property (p_push)
    else $error("push order wrong");
  property p_vec;
    $rose(in_dispatch) |-> ##4 (flags == 8'h00 && program_counter[15:8] == 8'h00);
  endproperty
  a_vec: assert property (p_vec)
    else $error("flags or counter high byte not cleared");
  property p_nest;
    flags_wr && !in_dispatch && !ret_valid |=> global_int_enable == $past(flags_wdata[0]);
  endproperty
  a_nest: assert property (p_nest)
    else $error("software enable write lost");
endmodule

bind irq_sequencer irq_checker chk_i (
  .core_clk, .resetn, .flags_wr, .flags_wdata, .ret_valid, .ret_pc, .ret_flags,
  .instr_start, .instr_is_short_jump, .instr_ready, .program_counter, .flags,
  .global_int_enable, .stack_wr, .stack_wdata, .instr_finish, .isr_start, .in_dispatch
);

// ==== sim/core_model.sv ====
module core_model (
  input wire logic        core_clk,
  input wire logic        instr_ready,
  input wire logic        go,
  input wire logic        is_sh,
  input wire logic [3:0]  len,
  input wire logic [15:0] pc_in,
  output logic            instr_start,
  output logic            instr_is_short_jump,
  output logic [3:0]      instr_cycles,
  output logic [15:0]     next_pc
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    instr_start = 1'b0;
    instr_is_short_jump = 1'b0;
    instr_cycles = 4'h1;
    next_pc = 16'h0000;
  end
  // A refused request is held unchanged until the sequencer is ready again.
  always @(posedge core_clk)
    if (instr_start && instr_ready)
    begin
      instr_start <= 1'b0;
      instr_is_short_jump <= ~instr_is_short_jump;
      instr_cycles <= ~instr_cycles;
      next_pc <= ~next_pc;
    end
    else if (go && !instr_start)
    begin
      instr_start <= 1'b1;
      instr_is_short_jump <= is_sh;
      instr_cycles <= len;
      next_pc <= pc_in;
    end
endmodule

// ==== sim/interrupt_return_latency_bench.sv ====
module interrupt_return_latency_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] VT = 16'h0ABC;
  logic core_clk, resetn, go, is_sh, flags_wr, ret_valid, instr_start, instr_is_short_jump;
  logic instr_ready, global_int_enable, stack_wr, instr_finish, isr_start, in_dispatch;
  logic [7:0] int_cond, int_mask_regs, flags_wdata, ret_flags, flags, stack_wdata;
  logic [3:0] len, instr_cycles;
  logic [15:0] pc_in, next_pc, ret_pc, program_counter;
  logic [7:0] sq[$];
  int bad_count, num_checks, cyc, n;
  irq_sequencer uut (.core_clk, .resetn, .int_cond, .int_clr(8'h00), .int_mask_regs,
    .instr_start, .instr_is_short_jump, .instr_cycles, .next_pc, .flags_wr, .flags_wdata,
    .ret_valid, .ret_pc, .ret_flags, .vec_target(VT), .instr_ready, .program_counter,
    .flags, .global_int_enable, .stack_wr, .stack_wdata, .instr_finish, .isr_start,
    .in_dispatch);
  core_model m (.core_clk, .instr_ready, .go, .is_sh, .len, .pc_in, .instr_start,
    .instr_is_short_jump, .instr_cycles, .next_pc);
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    if (stack_wr) sq.push_back(stack_wdata);
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      wrap_up;
    end
  end
  task tick; @(posedge core_clk); #1; endtask
  task chk(input string s, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("FAIL %s expected %h seen %h", s, e, g);
      bad_count++;
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task issue(input logic s, input logic [3:0] l, input logic [15:0] p);
    go = 1'b1; is_sh = s; len = l; pc_in = p;
    for (int i = 0; i < 60 && !(instr_start && instr_ready); i++) tick;
    tick;
    go = 1'b0;
  endtask
  task wait_ev(input logic sel);
    n = 0;
    do begin tick; n++; end while (!(sel ? isr_start : instr_finish) && n < 60);
  endtask
  task t_instr;
    issue(0, 4'h2, 16'h1234); wait_ev(0);
    chk("length", 16'd2, 16'(n));
    chk("counter", 16'h1234, program_counter);
    issue(1, 4'h0, 16'h1240); wait_ev(0);
    chk("short length", 16'(irq_seq_pkg::SHORT_JUMP_CYCLES), 16'(n));
  endtask
  task t_latency;
    flags_wr = 1'b1; flags_wdata = 8'h01; int_mask_regs = 8'h04; tick;
    flags_wr = 1'b0; sq.delete();
    issue(1, 4'h0, 16'h2345); int_cond = 8'h04; tick;
    int_cond = 8'h00; wait_ev(1);
    // The request shows one cycle into the short jump, so four of its cycles remain.
    chk("latency", 16'(irq_seq_pkg::SHORT_JUMP_CYCLES - 1 + irq_seq_pkg::DISPATCH_CYCLES
      + irq_seq_pkg::LONG_JUMP_CYCLES), 16'(n));
    chk("enable in routine", 16'h0, 16'(global_int_enable));
    chk("routine entry", VT, program_counter);
    chk("push", 16'h2345, {sq[0], sq[1]});
    chk("pushed flags", 16'h01, 16'(sq[2]));
  endtask
  task t_return;
    int_mask_regs = 8'h24; int_cond = 8'h20; tick;
    int_cond = 8'h00; tick;
    chk("held off", 16'h1, 16'(instr_ready));
    sq.delete(); ret_valid = 1'b1; ret_pc = 16'h2345; ret_flags = 8'h01; tick;
    ret_valid = 1'b0;
    chk("restored counter", 16'h2345, program_counter);
    chk("restored enable", 16'h1, 16'(global_int_enable));
    issue(0, 4'h1, 16'h5555);
    chk("dispatched first", 16'h2345, {sq[0], sq[1]});
    wait_ev(0);
    chk("resumed", 16'h5555, program_counter);
  endtask
  task t_mask;
    int_mask_regs = 8'h00; int_cond = 8'h40; tick;
    int_cond = 8'h00; flags_wr = 1'b1; tick;
    flags_wr = 1'b0; tick; tick;
    chk("masked", 16'h1, 16'(instr_ready && !in_dispatch));
    sq.delete(); int_mask_regs = 8'h40; wait_ev(1);
    chk("unmask dispatch", 16'h1, 16'(n <= 22 && sq.size() == 3));
  endtask
  initial
  begin
    resetn = 1'b0; go = 1'b0; is_sh = 1'b0; len = 4'h1; pc_in = 16'h0000;
    flags_wr = 1'b0; flags_wdata = 8'h01; ret_valid = 1'b0; ret_pc = 16'h0000;
    ret_flags = 8'h00; int_cond = 8'h00; int_mask_regs = 8'h00;
    repeat (16) @(posedge core_clk);
    #1 resetn = 1'b1;
    t_instr;
    t_latency;
    t_return;
    t_mask;
    wrap_up;
  end
endmodule
